/* plc_cell.sv */
`timescale 1ns/1ns
`default_nettype none
`include "plc_params.svh"
// How it works
// (R1) each gate ands any subset of four inputs, true or inverted
// (R2) each gate result has its own inversion before the function stage
// (R3) gate with no enables gives constant level set by its polarity
// (R4) enables 0x55 give and/nand, 0xaa give nor/or by polarity
// (R5) true and inverted of one input together force the gate low
// (R6) software uses polarity alone for fixed levels, never both senses
// (R7) four gate enable groups, numbered zero to three, one per gate
// (R8) eight selectable functions of the four gate outputs, incl. storage
// (R9) final output goes to peripherals, a pin and back to inputs
// (R10) output invert flips the function result into the final output
// (R11) flipping output invert counts as an edge for interrupts
// (R12) rising and falling edge detectors watch the final output
// (R13) flag sets on enabled rising edge or enabled falling edge
// (R14) software clears flag; a coincident new edge keeps it set
// (R15) request needs cell, edge, peripheral and global enables all set; code gates the flag with cell, peripheral and global enables only
// (R16) mirror port presents every cell's output sampled together
// (R17) reset clears the control bits; selections and gating persist
// (R18) gate enables carry no defined reset value
// (R19) cell logic runs without the system clock, also in sleep
// (R20) fast oscillator request held while enabled and selected as input
// (R21) software disables, configures fully, then re-enables the cell
// (R22) function codes map 000 and-or through 111 transparent latch
// (R23) disabled cell drives output low, enabled follows the logic
// (R24) each data input has its own six-bit source select field
// (R25) edge detectors see the output through a two-stage synchroniser
module plc_cell
  import plc_pkg::*;
#(
  parameter int NUM_CELLS = `PLC_NUM_CELLS,
  parameter int CELL_INDEX = `PLC_CELL_INDEX,
  parameter logic [`PLC_SEL_WIDTH-1:0] FAST_OSC_CODE = 6'h05
) (
  // clock and reset
  input wire logic MCLK,
  input wire logic RST,
  // data from the source multiplexer and its selects
  input wire logic [`PLC_NUM_INPUTS-1:0] DATA_IN,
  input wire logic [`PLC_SEL_WIDTH-1:0] INPUT_SOURCE_SELECT_0,
  input wire logic [`PLC_SEL_WIDTH-1:0] INPUT_SOURCE_SELECT_1,
  input wire logic [`PLC_SEL_WIDTH-1:0] INPUT_SOURCE_SELECT_2,
  input wire logic [`PLC_SEL_WIDTH-1:0] INPUT_SOURCE_SELECT_3,
  // gating configuration
  input wire logic [`PLC_ENA_WIDTH-1:0] GATE_SOURCE_ENABLES_0,
  input wire logic [`PLC_ENA_WIDTH-1:0] GATE_SOURCE_ENABLES_1,
  input wire logic [`PLC_ENA_WIDTH-1:0] GATE_SOURCE_ENABLES_2,
  input wire logic [`PLC_ENA_WIDTH-1:0] GATE_SOURCE_ENABLES_3,
  input wire logic [`PLC_NUM_GATES-1:0] GATE_OUTPUT_INVERT,
  // cell control, cleared by reset
  input wire logic CELL_ENABLE,
  input wire logic [`PLC_MODE_WIDTH-1:0] FUNCTION_SELECT,
  input wire logic OUTPUT_INVERT,
  input wire logic RISE_IRQ_ENABLE,
  input wire logic FALL_IRQ_ENABLE,
  // interrupt enables and flag clear
  input wire logic CELL_IRQ_ENABLE,
  input wire logic PERIPHERAL_IRQ_ENABLE,
  input wire logic GLOBAL_IRQ_ENABLE,
  input wire logic CELL_IRQ_FLAG_CLEAR,
  // outputs of the other cells for the mirror
  input wire logic [NUM_CELLS-1:0] OTHER_CELL_OUTPUTS,
  // results
  output logic CELL_FINAL_OUTPUT,
  output logic CELL_OUTPUT_BIT,
  output logic [NUM_CELLS-1:0] ALL_OUTPUTS_MIRROR,
  output logic CELL_IRQ_FLAG,
  output logic IRQ_REQUEST,
  output logic FAST_OSC_REQUEST
);
  // ****************************************
  // elaboration checks
  // ****************************************
  initial begin
    if (NUM_CELLS < 1 || CELL_INDEX < 0 || CELL_INDEX >= NUM_CELLS) begin
      $error("plc_cell cell index out of range");
    end
  end

  // ****************************************
  // data gating
  // ****************************************
  logic [`PLC_NUM_GATES-1:0] gate;
  logic [`PLC_ENA_WIDTH-1:0] gate_ena [`PLC_NUM_GATES];

  // one enable group per gate, gate 0 uses group zero; no reset, so
  // these hold whatever software last wrote across resets
  always_comb begin
    gate_ena[0] = GATE_SOURCE_ENABLES_0; // [R7] [R18] [R17]
    gate_ena[1] = GATE_SOURCE_ENABLES_1; // [R7]
    gate_ena[2] = GATE_SOURCE_ENABLES_2; // [R7]
    gate_ena[3] = GATE_SOURCE_ENABLES_3; // [R7]
  end

  // software is expected to use polarity for fixed levels [R6]
  for (genvar g = 0; g < `PLC_NUM_GATES; g++) begin : g_gate
    plc_gate #(
      .NUM_IN(`PLC_NUM_INPUTS)
    ) u_gate (
      .data(DATA_IN),
      .enables(gate_ena[g]),
      .invert(GATE_OUTPUT_INVERT[g]),
      .result(gate[g])
    );
  end

  // ****************************************
  // logic function stage
  // ****************************************
  // storage functions are built from gate signals and CELL_ENABLE, not MCLK, so
  // the cell keeps working in sleep; the price is async feedback logic
  // that a timing tool must be told about
  logic fn_out;
  logic seq_q;
  logic lat_q;
  logic seq_clk;
  logic seq_d;
  logic seq_set;
  logic seq_rst;
  function_type mode;

  assign mode = function_type'(FUNCTION_SELECT);

  // clock, data, set and reset for the flip-flop modes
  always_comb begin
    seq_clk = gate[0];
    seq_d = gate[1];
    seq_set = 1'b0;
    seq_rst = 1'b0;
    case (mode)
      FN_DFF_SR: begin
        seq_set = gate[3];
        seq_rst = gate[2];
      end
      FN_DFF2_R: begin
        seq_d = gate[1] & gate[3];
        seq_rst = gate[2];
      end
      FN_JK_R: begin
        seq_rst = gate[3];
      end
      default: begin
      end
    endcase
  end

  // edge-clocked storage for modes 100..110, released only when enabled
  always_ff @(posedge seq_clk or posedge seq_rst or posedge seq_set
              or negedge CELL_ENABLE) begin
    if (!CELL_ENABLE) begin
      seq_q <= 1'b0;
    end else if (seq_rst) begin
      seq_q <= 1'b0;
    end else if (seq_set) begin
      seq_q <= 1'b1;
    end else if (mode == FN_JK_R) begin
      seq_q <= (gate[1] & ~seq_q) | (~gate[2] & seq_q); // [R8]
    end else begin
      seq_q <= seq_d; // [R8]
    end
  end

  // level storage for the sr latch and transparent latch modes
  always_latch begin
    if (!CELL_ENABLE) begin
      lat_q = 1'b0;
    end else if (mode == FN_SR_LATCH) begin
      if (gate[2] | gate[3]) begin
        lat_q = 1'b0;
      end else if (gate[0] | gate[1]) begin
        lat_q = 1'b1;
      end
    end else if (mode == FN_DLATCH_SR) begin
      if (gate[2]) begin
        lat_q = 1'b0;
      end else if (gate[3]) begin
        lat_q = 1'b1;
      end else if (gate[0]) begin
        lat_q = gate[1];
      end
    end
  end

  // function select decode
  always_comb begin
    case (mode)
      FN_AND_OR: fn_out = (gate[0] & gate[1]) | (gate[2] & gate[3]); // [R22]
      FN_OR_XOR: fn_out = (gate[0] | gate[1]) ^ (gate[2] | gate[3]); // [R22]
      FN_AND4: fn_out = &gate; // [R22]
      FN_SR_LATCH: fn_out = lat_q; // [R22]
      FN_DLATCH_SR: fn_out = lat_q; // [R22]
      default: fn_out = seq_q; // [R22] [R8]
    endcase
  end

  // ****************************************
  // output stage
  // ****************************************
  logic final_out;

  // disabled cell is low regardless of the invert bit
  assign final_out = CELL_ENABLE & (fn_out ^ OUTPUT_INVERT); // [R10] [R23]
  // same net to pin, peripherals and feedback source [R9] [R19]
  assign CELL_FINAL_OUTPUT = final_out;

  // ****************************************
  // edge detect and flag, register domain
  // ****************************************
  irq_state_type st_q;
  irq_state_type st_d;
  logic rise;
  logic fall;
  logic [NUM_CELLS-1:0] mirror_a_q;
  logic [NUM_CELLS-1:0] mirror_b_q;
  logic [NUM_CELLS-1:0] mirror_out;

  // other cells are async too, so they pass two flops like our own
  // output; every mirror bit then shows the same sampling edge
  always_comb begin
    mirror_out = mirror_b_q;
    mirror_out[CELL_INDEX] = st_q.sync_b; // [R16]
  end

  // final output is asynchronous to MCLK, so it is synchronised first
  always_comb begin
    st_d = st_q;
    st_d.sync_a = final_out; // [R25]
    st_d.sync_b = st_q.sync_a; // [R25]
    st_d.last = st_q.sync_b; // [R12]
    rise = st_q.sync_b & ~st_q.last; // [R12] [R11]
    fall = ~st_q.sync_b & st_q.last; // [R12] [R11]
    if ((rise & RISE_IRQ_ENABLE) | (fall & FALL_IRQ_ENABLE)) begin
      st_d.flag = 1'b1; // [R13] [R14]
    end else if (CELL_IRQ_FLAG_CLEAR) begin
      st_d.flag = 1'b0; // [R14]
    end
  end

  // flag and synchroniser live on MCLK; the cell itself does not
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      st_q <= '0;
      mirror_a_q <= '0;
      mirror_b_q <= '0;
    end else begin
      st_q <= st_d;
      mirror_a_q <= OTHER_CELL_OUTPUTS; // [R16]
      mirror_b_q <= mirror_a_q; // [R16]
    end
  end

  // all bits taken on one edge, so a read sees no skew between cells
  assign ALL_OUTPUTS_MIRROR = mirror_out; // [R16]
  assign CELL_OUTPUT_BIT = st_q.sync_b;
  assign CELL_IRQ_FLAG = st_q.flag;
  assign IRQ_REQUEST = st_q.flag & CELL_IRQ_ENABLE & PERIPHERAL_IRQ_ENABLE
                       & GLOBAL_IRQ_ENABLE; // [R15]

  // one decode shared by all four source selects
  function automatic logic picks_fast_osc(
    input logic [`PLC_SEL_WIDTH-1:0] sel
  );
    return sel == FAST_OSC_CODE; // [R24]
  endfunction

  // keep the fast oscillator alive while the cell is enabled and any input selects it [R20]
  always_comb begin
    FAST_OSC_REQUEST = CELL_ENABLE
      & (picks_fast_osc(INPUT_SOURCE_SELECT_0) // [R24]
       | picks_fast_osc(INPUT_SOURCE_SELECT_1)
       | picks_fast_osc(INPUT_SOURCE_SELECT_2)
       | picks_fast_osc(INPUT_SOURCE_SELECT_3));
  end
  // software sequence of disable, configure, enable is assumed [R21]
endmodule
`default_nettype wire

/* plc_cell_sva.sv */
`timescale 1ns/1ns
`default_nettype none
// ****************************************
// port checker for the logic cell
// ****************************************
module plc_cell_sva
  import plc_pkg::*;
#(
  parameter int NUM_CELLS = 4,
  parameter int CELL_INDEX = 0
) (
  // clock and reset
  input wire logic MCLK,
  input wire logic RST,
  // controls
  input wire logic CELL_ENABLE,
  input wire logic RISE_IRQ_ENABLE,
  input wire logic FALL_IRQ_ENABLE,
  input wire logic CELL_IRQ_ENABLE,
  input wire logic PERIPHERAL_IRQ_ENABLE,
  input wire logic GLOBAL_IRQ_ENABLE,
  input wire logic CELL_IRQ_FLAG_CLEAR,
  input wire logic [NUM_CELLS-1:0] OTHER_CELL_OUTPUTS,
  // results
  input wire logic CELL_FINAL_OUTPUT,
  input wire logic CELL_OUTPUT_BIT,
  input wire logic [NUM_CELLS-1:0] ALL_OUTPUTS_MIRROR,
  input wire logic CELL_IRQ_FLAG,
  input wire logic IRQ_REQUEST
);
  // mirror position that belongs to this cell
  localparam logic [NUM_CELLS-1:0] OWN_MASK = NUM_CELLS'(1) << CELL_INDEX;
  default clocking @(posedge MCLK); endclocking
  default disable iff (RST);
  // output path, synchroniser and mirror
  a_off_low: assert property (!CELL_ENABLE |-> !CELL_FINAL_OUTPUT)
    else $error("output high while disabled");
  a_sync_lag: assert property (
    CELL_OUTPUT_BIT == $past(CELL_FINAL_OUTPUT, 2))
    else $error("synchronised output wrong");
  // reset clears both mirror stages, so skip the two release edges
  a_mirror_all: assert property (!$past(RST) && !$past(RST, 2) |->
    ((ALL_OUTPUTS_MIRROR ^ $past(OTHER_CELL_OUTPUTS, 2)) & ~OWN_MASK) == '0
    && ALL_OUTPUTS_MIRROR[CELL_INDEX] == $past(CELL_FINAL_OUTPUT, 2))
    else $error("mirror not sampled together");
  // edge detection and the sticky flag
  a_rise_flag: assert property (
    $rose(CELL_OUTPUT_BIT) && RISE_IRQ_ENABLE |=> CELL_IRQ_FLAG)
    else $error("rising edge missed");
  a_fall_flag: assert property (
    $fell(CELL_OUTPUT_BIT) && FALL_IRQ_ENABLE |=> CELL_IRQ_FLAG)
    else $error("falling edge missed");
  a_quiet_low: assert property (
    !CELL_IRQ_FLAG && $stable(CELL_OUTPUT_BIT) |=> !CELL_IRQ_FLAG)
    else $error("flag set without edge");
  a_flag_hold: assert property (
    CELL_IRQ_FLAG && !CELL_IRQ_FLAG_CLEAR |=> CELL_IRQ_FLAG)
    else $error("flag dropped without clear");
  a_clear_drops: assert property (
    CELL_IRQ_FLAG_CLEAR && $stable(CELL_OUTPUT_BIT) |=> !CELL_IRQ_FLAG)
    else $error("clear ignored");
  a_req_gate: assert property (IRQ_REQUEST == (CELL_IRQ_FLAG &&
    CELL_IRQ_ENABLE && PERIPHERAL_IRQ_ENABLE && GLOBAL_IRQ_ENABLE))
    else $error("request gating wrong");
endmodule
bind plc_cell plc_cell_sva #(.NUM_CELLS(NUM_CELLS),
  .CELL_INDEX(CELL_INDEX)) sva_u (.*);
`default_nettype wire

/* plc_cell_tb.sv */
`timescale 1ns/1ns
`default_nettype none
// ****************************************
// self-checking bench for the logic cell
// ****************************************
module plc_cell_tb
  import plc_pkg::*;
;
  logic mclk = 1'b0, rst = 1'b1, hold = 1'b0, en = 1'b0, oinv = 1'b0;
  logic rie = 1'b0, fie = 1'b0, cie = 1'b0, pie = 1'b0, global_irq_enable = 1'b0;
  logic clr = 1'b0, st, pg0, o;
  logic [2:0] fsel = 3'h0;
  logic [3:0] ginv = 4'h0, g;
  logic [7:0] gen [4];
  logic [5:0] sel [4];
  wire logic [3:0] din, oth, mir;
  wire logic fo, ob, flag, req, osc;
  int err_count = 0, n_tests = 0, cyc = 0;

  plc_source_model src_u (.MCLK(mclk), .HOLD(hold), .DATA_IN(din),
    .OTHER_CELL_OUTPUTS(oth));
  plc_cell dut_u (.MCLK(mclk), .RST(rst), .DATA_IN(din),
    .INPUT_SOURCE_SELECT_0(sel[0]), .INPUT_SOURCE_SELECT_1(sel[1]),
    .INPUT_SOURCE_SELECT_2(sel[2]), .INPUT_SOURCE_SELECT_3(sel[3]),
    .GATE_SOURCE_ENABLES_0(gen[0]), .GATE_SOURCE_ENABLES_1(gen[1]),
    .GATE_SOURCE_ENABLES_2(gen[2]), .GATE_SOURCE_ENABLES_3(gen[3]),
    .GATE_OUTPUT_INVERT(ginv), .CELL_ENABLE(en), .FUNCTION_SELECT(fsel),
    .OUTPUT_INVERT(oinv), .RISE_IRQ_ENABLE(rie), .FALL_IRQ_ENABLE(fie),
    .CELL_IRQ_ENABLE(cie), .PERIPHERAL_IRQ_ENABLE(pie),
    .GLOBAL_IRQ_ENABLE(global_irq_enable), .CELL_IRQ_FLAG_CLEAR(clr),
    .OTHER_CELL_OUTPUTS(oth), .CELL_FINAL_OUTPUT(fo), .CELL_OUTPUT_BIT(ob),
    .ALL_OUTPUTS_MIRROR(mir), .CELL_IRQ_FLAG(flag), .IRQ_REQUEST(req),
    .FAST_OSC_REQUEST(osc));

  // clock and hang guard
  initial forever #5 mclk = ~mclk;
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      print_verdict();
    end
  end

  task automatic check(input logic [3:0] seen, input logic [3:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // empty and of enabled terms is one; polarity low inverts
  function automatic logic gate(logic [3:0] d, logic [7:0] e, logic p);
    logic a;
    a = 1'b1;
    for (int i = 0; i < 4; i++) begin
      if ((e[2*i] && !d[i]) || (e[2*i+1] && d[i])) a = 1'b0;
    end
    return p ? a : !a;
  endfunction

  function automatic logic comb(logic [2:0] m, logic [3:0] x);
    case (m)
      3'h0: return (x[0] & x[1]) | (x[2] & x[3]);
      3'h1: return (x[0] | x[1]) ^ (x[2] | x[3]);
      default: return &x;
    endcase
  endfunction

  // storage reference with g0 clock, g1 data, g2 and g3 held idle
  task automatic seq_step(input int m);
    if ((m == 4 || m == 5) && din[0] && !pg0) st = din[1];
    if (m == 6 && din[0] && !pg0 && din[1]) st = 1'b1;
    if (m == 3 && (din[0] || din[1])) st = 1'b1;
    if (m == 7 && din[0]) st = din[1];
    pg0 = din[0];
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask

  // main sequence
  initial begin
    void'($urandom(32'h3b554684));
    for (int i = 0; i < 4; i++) begin
      gen[i] = 8'h00;
      sel[i] = 6'h00;
    end
    tick(5);
    rst <= 1'b0;
    repeat (600) begin
      tick(1);
      en <= 1'b1;
      fsel <= 3'($urandom_range(0, 2));
      oinv <= 1'($urandom);
      ginv <= 4'($urandom);
      for (int i = 0; i < 4; i++) begin
        case ($urandom_range(0, 3))
          0: gen[i] <= 8'h55;
          1: gen[i] <= 8'haa;
          2: gen[i] <= 8'h00;
          default: gen[i] <= 8'($urandom);
        endcase
        sel[i] <= $urandom_range(0, 1) ? 6'h05 : 6'($urandom);
      end
      @(negedge mclk);
      o = 1'b0;
      for (int i = 0; i < 4; i++) begin
        g[i] = gate(din, gen[i], ginv[i]);
        o = o | (sel[i] == 6'h05);
      end
      check(fo, comb(fsel, g) ^ oinv);
      check(osc, o);
    end
    for (int m = 3; m < 8; m++) begin
      tick(1);
      hold <= 1'b1;
      en <= 1'b0;
      fsel <= 3'(m);
      ginv <= {m == 5, 3'h3};
      gen[0] <= 8'h01;
      gen[1] <= 8'h04;
      gen[2] <= 8'h00;
      gen[3] <= 8'h00;
      @(negedge mclk);
      check(fo, 4'h0);
      check(osc, 4'h0);
      st = 1'b0;
      pg0 = din[0];
      tick(1);
      en <= 1'b1;
      repeat (80) begin
        tick(1);
        hold <= 1'($urandom);
        @(negedge mclk);
        seq_step(m);
        check(fo, st ^ oinv);
      end
    end
    // output invert flips make the edges; all gates idle low
    tick(1);
    hold <= 1'b1;
    fsel <= 3'h2;
    ginv <= 4'h0;
    {rie, cie, pie, global_irq_enable} <= 4'hf;
    for (int i = 0; i < 4; i++) gen[i] <= 8'h00;
    tick(1);
    oinv <= 1'b0;
    tick(4);
    // drop any flag left by the mode change before the real edge
    clr <= 1'b1;
    tick(1);
    clr <= 1'b0;
    oinv <= 1'b1;
    @(negedge mclk);
    check(flag, 4'h0);
    tick(4);
    @(negedge mclk);
    check({flag, req}, 4'h3);
    check(ob, 4'h1);
    check(mir, {oth[3:1], fo});
    for (int k = 0; k < 8; k++) begin
      tick(1);
      {cie, pie, global_irq_enable} <= 3'(k);
      @(negedge mclk);
      check(req, k == 7);
    end
    tick(1);
    fie <= 1'b1;
    oinv <= 1'b0;
    tick(2);
    clr <= 1'b1;
    tick(1);
    clr <= 1'b0;
    @(negedge mclk);
    check(flag, 4'h1);
    tick(1);
    clr <= 1'b1;
    tick(1);
    clr <= 1'b0;
    {rie, fie} <= 2'h0;
    tick(1);
    oinv <= 1'b1;
    tick(4);
    oinv <= 1'b0;
    tick(4);
    @(negedge mclk);
    check(flag, 4'h0);
    tick(1);
    fie <= 1'b1;
    oinv <= 1'b1;
    tick(1);
    oinv <= 1'b0;
    tick(4);
    @(negedge mclk);
    check(flag, 4'h1);
    tick(1);
    rst <= 1'b1;
    en <= 1'b0;
    tick(3);
    @(negedge mclk);
    check({flag, req}, 4'h0);
    tick(1);
    rst <= 1'b0;
    tick(3);
    print_verdict();
  end
endmodule
`default_nettype wire

/* plc_gate.sv */
`timescale 1ns/1ns
`default_nettype none
`include "plc_params.svh"
// one data gate: and of the enabled true or inverted inputs
module plc_gate
  import plc_pkg::*;
#(
  parameter int NUM_IN = `PLC_NUM_INPUTS
) (
  // selected data
  input wire logic [NUM_IN-1:0] data,
  // configuration
  input wire logic [2*NUM_IN-1:0] enables,
  input wire logic invert,
  // result
  output logic result
);
  // ****************************************
  // gate
  // ****************************************
  initial begin
    if (NUM_IN < 1) begin
      $error("plc_gate needs at least one input");
    end
  end

  // even bits take input true, odd bits take it inverted; no enable gives 1
  always_comb begin
    logic acc;
    acc = 1'b1;
    for (int i = 0; i < NUM_IN; i++) begin
      if (enables[2*i] && !data[i]) begin // [R1]
        acc = 1'b0;
      end
      if (enables[2*i+1] && data[i]) begin // [R1] [R5]
        acc = 1'b0;
      end
    end
    // 0x55 with invert=1 reads as and in this encoding, so invert=0 flips
    result = invert ? acc : ~acc; // [R2] [R3] [R4]
  end
endmodule
`default_nettype wire

/* plc_params.svh */
`ifndef PLC_PARAMS_SVH
`define PLC_PARAMS_SVH
// ****************************************
// cell constants
// ****************************************
`define PLC_NUM_INPUTS 4
`define PLC_NUM_GATES 4
`define PLC_SEL_WIDTH 6
`define PLC_ENA_WIDTH 8
`define PLC_MODE_WIDTH 3
`define PLC_NUM_CELLS 4
`define PLC_CELL_INDEX 0
`define PLC_MODE_AND_OR 3'h0
`define PLC_MODE_OR_XOR 3'h1
`define PLC_MODE_AND4 3'h2
`define PLC_MODE_SR_LATCH 3'h3
`define PLC_MODE_DFF_SR 3'h4
`define PLC_MODE_DFF2_R 3'h5
`define PLC_MODE_JK_R 3'h6
`define PLC_MODE_DLATCH_SR 3'h7
`define PLC_SYNC_STAGES 2
`endif

/* plc_pkg.sv */
package plc_pkg;
  // ****************************************
  // types
  // ****************************************
  typedef enum logic [2:0] {
    FN_AND_OR = 3'h0,
    FN_OR_XOR = 3'h1,
    FN_AND4 = 3'h2,
    FN_SR_LATCH = 3'h3,
    FN_DFF_SR = 3'h4,
    FN_DFF2_R = 3'h5,
    FN_JK_R = 3'h6,
    FN_DLATCH_SR = 3'h7
  } function_type;
  // output side state of the cell in the register clock domain
  typedef struct packed {
    logic sync_a;
    logic sync_b;
    logic last;
    logic flag;
  } irq_state_type;
endpackage

/* plc_source_model.sv */
`timescale 1ns/1ns
`default_nettype none
// ****************************************
// far side: selected sources and other cells
// ****************************************
module plc_source_model
  import plc_pkg::*;
(
  // clock and pacing
  input wire logic MCLK,
  input wire logic HOLD,
  // driven levels
  output logic [3:0] DATA_IN = 4'h0,
  output logic [3:0] OTHER_CELL_OUTPUTS = 4'h0
);
  logic phase_q = 1'b0;
  // input 0 and the rest change on alternate edges, so a storage
  // clock never moves together with its data (no setup race)
  always @(posedge MCLK) begin
    if (!HOLD) begin
      phase_q <= !phase_q;
      DATA_IN <= phase_q ? {3'($urandom), DATA_IN[0]}
                         : {DATA_IN[3:1], 1'($urandom)};
      OTHER_CELL_OUTPUTS <= 4'($urandom);
    end
  end
endmodule
`default_nettype wire
